// ==== src/register_reservation_scoreboard.sv ====
// Scoreboard control: reservations, ready flags, store and read grants
`timescale 1ns/1ps
`include "sb_cfg.svh"
// What this block does
// - Units carry fixed octal reservation codes
// - Issue writes unit code into result entry
// - Reserved result register blocks issue
// - Reserved operand still issues, copies tag
// - Function field picks one result group
// - Operand entries four bits, others two
// - 5X with nonzero i reserves address and paired operand
// - Tag match or zero sets ready flag
// - Read only with both flags set
// - Store grant clears busy and entry
// - Store compares every tag, sets flags
// - Several units may read together
// - Each release request held in flop
// - Store waits while readers hold flags
// - Test only groups the reader uses
// - Release needs request, all clear, priority
// - Fixed store priority per trunk group
// - Increment priority applied after release flop
// - Fixed read priority per trunk group
// - Release commands transmit and next reader
// - Release clears request, busy, entry, sends dest
// - Read grant clears flags, sets in-progress
// - Unit free one cycle after store
module register_reservation_scoreboard #(
  parameter int NU = `SB_NUM_UNITS,  // Scoreboard units
  parameter int NM = `SB_NUM_MEMCH   // Memory read channels
) (
  // Clock and reset
  input  wire logic                 clk_sys_i,
  input  wire logic                 rst_i,
  // APB slave
  input  wire sb_pkg::apb_req_t     apb_i,
  output logic                      pready_o,
  output logic                      pslverr_o,
  output logic [31:0]               prdata_o,
  // Instruction issue
  input  wire sb_pkg::issue_t       issue_i,
  output logic                      issue_ready_o,
  // Functional unit side
  input  wire logic [NU-1:0]        req_release_i,
  input  wire logic [NM-1:0]        mem_release_i,
  output logic [NU-1:0]             go_store_o,
  output sb_pkg::sel_t [NU-1:0]     store_dest_o,
  output logic [NU-1:0]             go_read_o,
  output sb_pkg::sel_t [NU-1:0]     read_j_o,
  output sb_pkg::sel_t [NU-1:0]     read_k_o
);

  // Unit index to reservation code
  function automatic logic [3:0] code_of(input int u);
    case (u)
      0:       code_of = `SB_CODE_INC1;
      1:       code_of = `SB_CODE_INC2;
      2:       code_of = `SB_CODE_SHIFT;
      3:       code_of = `SB_CODE_BOOL;
      4:       code_of = `SB_CODE_DIV;
      5:       code_of = `SB_CODE_MUL1;
      6:       code_of = `SB_CODE_MUL2;
      7:       code_of = `SB_CODE_LADD;
      default: code_of = `SB_CODE_ADD;
    endcase
  endfunction

  // Higher store priority units, per trunk group
  function automatic logic [8:0] store_hi(input int u);
    case (u)
      2:       store_hi = 9'h100;        // Shift under add
      7:       store_hi = 9'h104;        // Long add under add, shift
      5:       store_hi = 9'h010;        // Multiply 1 under divide
      6:       store_hi = 9'h030;
      3:       store_hi = 9'h070;        // Boolean last
      default: store_hi = 9'h000;        // Add, divide, increments
    endcase
  endfunction

  // Higher read priority units, per trunk group
  function automatic logic [8:0] read_hi(input int u);
    case (u)
      8:       read_hi = 9'h004;         // Add under shift
      7:       read_hi = 9'h104;
      4:       read_hi = 9'h008;         // Divide under boolean
      5:       read_hi = 9'h018;
      6:       read_hi = 9'h038;
      1:       read_hi = 9'h001;         // Increment 2 under 1
      default: read_hi = 9'h000;
    endcase
  endfunction

  // Reservation list: X four bits, B and A two bits
  logic [3:0]  x_res_q [8];
  logic [1:0]  b_res_q [8];
  logic [1:0]  a_res_q [8];
  // Per unit scoreboard state
  logic [NU-1:0] busy_q, req_q, rel_q, rd_q;
  logic [NU-1:0] rfj_q, rfk_q;
  sb_pkg::sel_t  fi_q [NU];
  sb_pkg::sel_t  fj_q [NU];
  sb_pkg::sel_t  fk_q [NU];
  logic [3:0]    qj_q [NU];
  logic [3:0]    qk_q [NU];
  logic [31:0]   ctrl_q;                 // Bit 0 holds issue
  // Combinational terms
  logic [NU-1:0] iss_u, cand, rdy, all_clr;
  logic [15:0]   released;               // Codes freed this cycle
  logic          iss, dual;
  sb_pkg::sel_t  dest;
  logic [3:0]    tag_j, tag_k;

  // Read a reservation entry as a four-bit code
  function automatic logic [3:0] res_of(input sb_pkg::sel_t s);
    case (s.grp)
      `SB_GRP_X: res_of = x_res_q[s.num];
      `SB_GRP_B: res_of = {2'h0, b_res_q[s.num]};
      `SB_GRP_A: res_of = {2'h0, a_res_q[s.num]};
      default:   res_of = 4'h0;
    endcase
  endfunction

  // Result group decode from the function field
  always_comb
  begin
    dest = '{grp: `SB_GRP_X, num: issue_i.i};
    case (issue_i.function_field[5:3])
      `SB_FN_AI: dest = '{grp: `SB_GRP_A, num: issue_i.i};
      `SB_FN_BI: dest = '{grp: `SB_GRP_B, num: issue_i.i};
      `SB_FN_BJ: dest = '{grp: `SB_GRP_B, num: issue_i.j};
      default:   dest = '{grp: `SB_GRP_X, num: issue_i.i};
    endcase
    // Address change with nonzero i also reserves the paired operand register
    dual = (issue_i.function_field[5:3] == `SB_FN_AI) && (issue_i.i != 3'h0);
  end

  // Issue acceptance and target unit decode
  always_comb
  begin
    iss_u = '0;
    for (int u = 0; u < NU; u++)
      iss_u[u] = (issue_i.unit_code == code_of(u)) && !busy_q[u];
    // Reserved result register stalls issue; unknown code refused
    issue_ready_o = (|iss_u) && !ctrl_q[0] && (res_of(dest) == 4'h0)
                    && !(dual && x_res_q[issue_i.i] != 4'h0);
    iss = issue_i.valid && issue_ready_o;
    // Tags copied from the list, even when reserved
    tag_j = res_of(issue_i.first_operand_designator);
    tag_k = res_of(issue_i.second_operand_designator);
  end

  // Codes released this cycle by store grants or memory channels
  always_comb
  begin
    released = '0;
    for (int u = 0; u < NU; u++)
      if (go_store_o[u])
        released[code_of(u)] = 1'b1;
    for (int m = 0; m < NM; m++)
      if (mem_release_i[m])
        released[`SB_CODE_MEM1 + 4'(m)] = 1'b1;
    released[`SB_CODE_BRANCH] = 1'b0;   // Zero never names a unit
  end

  // All clear: no other issued unit holds a flag on our result
  always_comb
  begin
    all_clr = '1;
    for (int u = 0; u < NU; u++)
      for (int v = 0; v < NU; v++)
        if (v != u && busy_q[v] &&
            ((rfj_q[v] && fj_q[v] == fi_q[u]) ||
             (rfk_q[v] && fk_q[v] == fi_q[u])))
          all_clr[u] = 1'b0;
  end

  // Store candidates and read candidates
  always_comb
  begin
    for (int u = 0; u < NU; u++)
    begin
      cand[u] = req_q[u] && busy_q[u] && all_clr[u] && !rel_q[u];
      rdy[u]  = busy_q[u] && !rd_q[u] && rfj_q[u] && rfk_q[u];
    end
    for (int u = 0; u < NU; u++)
      go_read_o[u] = rdy[u] && !(|(rdy & read_hi(u)));
    // Increment priority sits after the release flops
    go_store_o    = rel_q;
    go_store_o[1] = rel_q[1] && !rel_q[0];
  end

  // Reservation list update, X, B and A entries of one index per generate step
  for (genvar r = 0; r < 8; r++)
  begin : g_res
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
      if (rst_i)
      begin
        x_res_q[r] <= 4'h0;
        b_res_q[r] <= 2'h0;
        a_res_q[r] <= 2'h0;
      end
      else
      begin
        // Release clears entries first, a new reservation wins
        if (released[x_res_q[r]])
          x_res_q[r] <= 4'h0;
        if (released[{2'h0, b_res_q[r]}])
          b_res_q[r] <= 2'h0;
        if (released[{2'h0, a_res_q[r]}])
          a_res_q[r] <= 2'h0;
        if (iss && dest.num == 3'(r))
          case (dest.grp)
            `SB_GRP_X: x_res_q[r] <= issue_i.unit_code;
            `SB_GRP_B: b_res_q[r] <= issue_i.unit_code[1:0];
            `SB_GRP_A: a_res_q[r] <= issue_i.unit_code[1:0];
            default:   ;
          endcase
        // Paired X held by a memory channel, or by the unit on writes
        if (iss && dual && issue_i.i == 3'(r))
          x_res_q[r] <= (r <= NM) ? (`SB_CODE_UNUSED + 4'(r))
                                  : issue_i.unit_code;
      end
    end
  end

  // Per unit flops, one generate step per unit
  for (genvar u = 0; u < NU; u++)
  begin : g_unit
    // Busy, request, release and read-in-progress
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
      if (rst_i)
      begin
        busy_q[u] <= 1'b0;
        req_q[u]  <= 1'b0;
        rel_q[u]  <= 1'b0;
        rd_q[u]   <= 1'b0;
      end
      else
      begin
        // Busy drops at store grant, unit free the cycle after
        busy_q[u] <= iss_u[u] && iss ? 1'b1 : busy_q[u] && !go_store_o[u];
        // New request wins over the clear
        req_q[u]  <= (req_q[u] && !go_store_o[u]) || req_release_i[u];
        // Release needs request, all clear and trunk priority
        if (u <= 1)
          rel_q[u] <= cand[u] || (rel_q[u] && !go_store_o[u]);
        else
          rel_q[u] <= cand[u] && !(|(cand & store_hi(u)));
        rd_q[u]   <= go_read_o[u] || (rd_q[u] && !go_store_o[u]);
      end
    end

    // Designators and tags loaded at issue
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
      if (rst_i)
      begin
        fi_q[u] <= '0;
        fj_q[u] <= '0;
        fk_q[u] <= '0;
        qj_q[u] <= 4'h0;
        qk_q[u] <= 4'h0;
      end
      else if (iss && iss_u[u])
      begin
        fi_q[u] <= dest;
        fj_q[u] <= issue_i.first_operand_designator;
        fk_q[u] <= issue_i.second_operand_designator;
        qj_q[u] <= tag_j;
        qk_q[u] <= tag_k;
      end
    end

    // Operand ready flags
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
      if (rst_i)
      begin
        rfj_q[u] <= 1'b0;
        rfk_q[u] <= 1'b0;
      end
      else if (iss && iss_u[u])
      begin
        // Unreserved operand ready at once
        rfj_q[u] <= (tag_j == 4'h0) || released[tag_j];
        rfk_q[u] <= (tag_k == 4'h0) || released[tag_k];
      end
      else if (go_read_o[u])
      begin
        rfj_q[u] <= 1'b0;
        rfk_q[u] <= 1'b0;
      end
      else if (busy_q[u] && !rd_q[u])
      begin
        // Read in progress blocks any further update
        rfj_q[u] <= rfj_q[u] || released[qj_q[u]];
        rfk_q[u] <= rfk_q[u] || released[qk_q[u]];
      end
    end

    // Register numbers to entry and exit logic
    assign store_dest_o[u] = fi_q[u];
    assign read_j_o[u]     = fj_q[u];
    assign read_k_o[u]     = fk_q[u];
  end

  // APB slave: zero wait, read data loaded in setup phase, write data taken in access phase
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ctrl_q    <= `SB_RST_CTRL;
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end
    else if (apb_i.psel && !apb_i.penable)
    begin
      pslverr_o <= !(apb_i.paddr == `SB_OFF_CTRL || apb_i.paddr == `SB_OFF_STATUS);
      case (apb_i.paddr)
        `SB_OFF_CTRL:   prdata_o <= ctrl_q;
        `SB_OFF_STATUS: prdata_o <= {14'h0, req_q, rd_q};
        default:        prdata_o <= 32'h0000_0000;
      endcase
    end
    else if (apb_i.psel && apb_i.penable && apb_i.pwrite && apb_i.paddr == `SB_OFF_CTRL)
      ctrl_q <= {31'h0, apb_i.pwdata[0]};  // Only the hold bit exists
  end

  assign pready_o = apb_i.psel && apb_i.penable;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  sequence s_add_store;
    go_store_o[8] ##1 !busy_q[8];
  endsequence

  a_issue_sets_busy: assert property (iss && iss_u[8] |=> busy_q[8])
    else $error("add busy not set after issue");
  a_res_add_code: assert property (iss && iss_u[8] && dest.grp == `SB_GRP_X
      |=> x_res_q[$past(dest.num)] == `SB_CODE_ADD)
    else $error("add code not written to list");
  a_store_frees: assert property (go_store_o[8] |-> s_add_store)
    else $error("busy not cleared after store");
  a_release_cause: assert property (rel_q[8] && !$past(rel_q[8]) |-> $past(req_q[8]))
    else $error("release without request");
  a_store_prio: assert property (rel_q[2] |-> !rel_q[8])
    else $error("shift released over add");
  a_inc_prio: assert property (go_store_o[1] |-> !rel_q[0])
    else $error("increment 2 stored over increment 1");
  a_read_clears: assert property (go_read_o[8] |=> !rfj_q[8] && !rfk_q[8] && rd_q[8])
    else $error("read grant did not clear flags");
  a_read_prio: assert property (go_read_o[8] |-> !rdy[2] && rfj_q[8] && rfk_q[8])
    else $error("add read over shift");
  a_reserved_stall: assert property (issue_ready_o |-> res_of(dest) == 4'h0)
    else $error("issue onto reserved register");

endmodule // register_reservation_scoreboard

// ==== src/sb_cfg.svh ====
// Scoreboard constants: unit codes, register groups, bus map
`ifndef SB_CFG_SVH
`define SB_CFG_SVH
`define SB_NUM_UNITS   9
`define SB_NUM_MEMCH   5
`define SB_CODE_BRANCH 4'h0
`define SB_CODE_INC1   4'h1
`define SB_CODE_INC2   4'h2
`define SB_CODE_SHIFT  4'h3
`define SB_CODE_BOOL   4'h4
`define SB_CODE_DIV    4'h5
`define SB_CODE_MUL1   4'h6
`define SB_CODE_MUL2   4'h7
`define SB_CODE_UNUSED 4'h8
`define SB_CODE_MEM1   4'h9
`define SB_CODE_LADD   4'he
`define SB_CODE_ADD    4'hf
`define SB_GRP_X       2'h0
`define SB_GRP_B       2'h1
`define SB_GRP_A       2'h2
`define SB_FN_AI       3'h5
`define SB_FN_BI       3'h6
`define SB_FN_XI       3'h7
`define SB_FN_BJ       3'h0
`define SB_OFF_CTRL    32'h0000_0000
`define SB_OFF_STATUS  32'h0000_0004
`define SB_RST_CTRL    32'h0000_0000
`endif

// ==== src/sb_pkg.sv ====
// Scoreboard types: register selects, issue word, bus request
package sb_pkg;
  typedef struct packed {
    logic [1:0] grp;
    logic [2:0] num;
  } sel_t;
  typedef struct packed {
    logic       valid;
    logic [3:0] unit_code;
    logic [5:0] function_field;
    logic [2:0] i;
    logic [2:0] j;
    logic [2:0] k;
    sel_t       first_operand_designator;
    sel_t       second_operand_designator;
  } issue_t;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;
endpackage

// ==== test/fu_model.sv ====
// Functional unit model: asks for release a fixed time after its read grant
`timescale 1ns/1ps
module fu_model #(
  parameter int NU  = 9,  // Units modelled
  parameter int LAT = 3   // Cycles from read grant to release request
) (
  // Clock and reset
  input  wire logic          clk_sys_i,
  input  wire logic          rst_i,
  // Grants from the scoreboard
  input  wire logic [NU-1:0] go_read_i,
  // Release requests
  output logic [NU-1:0]      req_release_o
);
  logic [NU-1:0][3:0] cnt_q;  // Countdown per unit, zero is idle

  // Request well before the result so store and next read follow at once
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt_q         <= '0;
      req_release_o <= '0;
    end
    else
    begin
      for (int u = 0; u < NU; u++)
      begin
        // One-cycle pulse, the scoreboard holds it in its own flop
        req_release_o[u] <= (cnt_q[u] == 4'h1);
        if (go_read_i[u])
          cnt_q[u] <= 4'(LAT);
        else if (cnt_q[u] != 4'h0)
          cnt_q[u] <= cnt_q[u] - 4'h1;
      end
    end
  end
endmodule // fu_model

// ==== test/register_reservation_scoreboard_tb.sv ====
// Testbench for the scoreboard control block
`timescale 1ns/1ps
`include "sb_cfg.svh"
module register_reservation_scoreboard_tb;
  localparam sb_pkg::sel_t X1 = {`SB_GRP_X, 3'h1};  // Operand register 1
  localparam sb_pkg::sel_t X2 = {`SB_GRP_X, 3'h2};  // Operand register 2
  localparam sb_pkg::sel_t X3 = {`SB_GRP_X, 3'h3};  // Operand register 3
  localparam sb_pkg::sel_t B0 = {`SB_GRP_B, 3'h0};  // Increment register 0
  logic               clk_sys_i;     // 25 MHz clock
  logic               rst_i;         // Active-high reset
  sb_pkg::apb_req_t   apb_q;         // APB request
  sb_pkg::issue_t     iss_q;         // Issue word
  logic [4:0]         mem_q;         // Memory channel deliveries
  logic [8:0]         req_w;         // Release requests from the model
  logic               pready_o;
  logic               pslverr_o;
  logic [31:0]        prdata_o;
  logic               issue_ready_o;
  logic [8:0]         go_store_o;
  logic [8:0]         go_read_o;
  sb_pkg::sel_t [8:0] store_dest_o;
  sb_pkg::sel_t [8:0] read_j_o;
  sb_pkg::sel_t [8:0] read_k_o;
  int                 cyc;           // Edge count
  int                 st_at[9];      // Edge of last store grant
  int                 rd_at[9];      // Edge of last read grant
  sb_pkg::sel_t       dest_at[9];    // Destination seen with store grant
  logic [9:0]         rjk_at[9];     // Operand registers seen with read grant
  int                 errors;
  int                 cmp_count;
  logic [31:0]        rd;
  logic               er;
  int                 t0;
  int                 t1;

  register_reservation_scoreboard dut_u (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .apb_i(apb_q), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .prdata_o(prdata_o), .issue_i(iss_q),
    .issue_ready_o(issue_ready_o), .req_release_i(req_w), .mem_release_i(mem_q),
    .go_store_o(go_store_o), .store_dest_o(store_dest_o), .go_read_o(go_read_o),
    .read_j_o(read_j_o), .read_k_o(read_k_o));

  fu_model fu_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .go_read_i(go_read_o),
    .req_release_o(req_w));

  // Clock source
  initial
  begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end

  // Grant monitor, edges counted so order can be compared later
  always @(posedge clk_sys_i)
  begin
    cyc <= cyc + 1;
    for (int u = 0; u < 9; u++)
    begin
      if (go_store_o[u] === 1'b1)
      begin
        st_at[u]   <= cyc;
        dest_at[u] <= store_dest_o[u];
      end
      if (go_read_o[u] === 1'b1)
      begin
        rd_at[u]  <= cyc;
        rjk_at[u] <= {read_j_o[u], read_k_o[u]};
      end
    end
  end

  // Compare and count
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One APB transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    @(posedge clk_sys_i);
    apb_q <= {1'b1, 1'b0, w, a, d};
    @(posedge clk_sys_i);
    apb_q.penable <= 1'b1;
    @(posedge clk_sys_i);
    // No wait limit here: only the watchdog ends a stuck transfer
    while (pready_o !== 1'b1)
      @(posedge clk_sys_i);
    r = prdata_o;
    e = pslverr_o;
    apb_q <= '0;
  endtask

  // Present an issue word until taken or 200 edges pass; returns the accepting edge
  task automatic issue(input logic [3:0] c, input logic [5:0] f, input logic [2:0] i,
    input sb_pkg::sel_t a, input sb_pkg::sel_t b, output int t);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    iss_q <= {1'b1, c, f, i, 6'h0, a, b};
    @(posedge clk_sys_i);
    while (issue_ready_o !== 1'b1 && n < 200)
    begin
      @(posedge clk_sys_i);
      n++;
    end
    chk("issue taken", 32'h1, {31'h0, issue_ready_o});
    t = cyc;
    iss_q <= '0;
  endtask

  // Verdict, reached from the main sequence or the watchdog
  task automatic end_sim;
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Watchdog, far beyond the hundred or so edges the sequence needs
  initial
  begin
    repeat (5000) @(posedge clk_sys_i);
    errors++;
    end_sim();
  end

  // Main sequence
  initial
  begin
    rst_i = 1'b1;
    apb_q = '0;
    iss_q = '0;
    mem_q = '0;
    errors = 0;
    cmp_count = 0;
    repeat (5) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    // Registers after reset, unmapped place refused
    apb(1'b0, `SB_OFF_STATUS, 32'h0, rd, er);
    chk("status", 32'h0, rd);
    chk("status err", 32'h0, {31'h0, er});
    apb(1'b0, 32'h0000_0040, 32'h0, rd, er);
    chk("unmapped err", 32'h1, {31'h0, er});
    // Hold bit stops issue
    apb(1'b1, `SB_OFF_CTRL, 32'h1, rd, er);
    apb(1'b0, `SB_OFF_CTRL, 32'h0, rd, er);
    chk("ctrl", 32'h1, rd);
    iss_q <= {1'b1, `SB_CODE_MUL1, 6'o40, 3'h1, 6'h0, X2, X3};
    repeat (2) @(posedge clk_sys_i);
    chk("held issue", 32'h0, {31'h0, issue_ready_o});
    iss_q <= '0;
    apb(1'b1, `SB_OFF_CTRL, 32'h0, rd, er);
    // Producer, waiting consumer, then a writer to the same result
    issue(`SB_CODE_MUL1, 6'o40, 3'h1, X2, X3, t0);
    issue(`SB_CODE_ADD, 6'o30, 3'h0, X1, X2, t1);
    @(posedge clk_sys_i);
    iss_q <= {1'b1, `SB_CODE_LADD, 6'o30, 3'h1, 6'h0, X2, X3};
    repeat (2) @(posedge clk_sys_i);
    chk("reserved result", 32'h0, {31'h0, issue_ready_o});
    issue(`SB_CODE_LADD, 6'o30, 3'h1, X2, X3, t1);
    // Monitor records by non-blocking update, so let one edge pass first
    @(posedge clk_sys_i);
    chk("mul1 read", 32'h1, {31'h0, rd_at[5] > t0});
    chk("mul1 operands", {22'h0, X2, X3}, {22'h0, rjk_at[5]});
    chk("mul1 store", 32'h1, {31'h0, st_at[5] > rd_at[5]});
    chk("mul1 dest", {27'h0, X1}, {27'h0, dest_at[5]});
    chk("add waits", 32'h1, {31'h0, rd_at[8] > st_at[5]});
    chk("add operands", {22'h0, X1, X2}, {22'h0, rjk_at[8]});
    chk("reissue late", 32'h1, {31'h0, t1 > st_at[5]});
    // Memory read keeps the paired operand register reserved
    repeat (20) @(posedge clk_sys_i);
    issue(`SB_CODE_INC1, 6'o51, 3'h1, B0, B0, t0);
    repeat (20) @(posedge clk_sys_i);
    chk("inc1 store", 32'h1, {31'h0, st_at[0] > t0});
    iss_q <= {1'b1, `SB_CODE_ADD, 6'o30, 3'h1, 6'h0, X2, X3};
    repeat (3) @(posedge clk_sys_i);
    chk("memory hold", 32'h0, {31'h0, issue_ready_o});
    mem_q <= 5'h01;
    t0 = cyc;
    @(posedge clk_sys_i);
    mem_q <= 5'h00;
    issue(`SB_CODE_ADD, 6'o30, 3'h1, X2, X3, t1);
    chk("after delivery", 32'h1, {31'h0, t1 > t0});
    repeat (30) @(posedge clk_sys_i);
    end_sim();
  end
endmodule // register_reservation_scoreboard_tb
